/* rtl/mmc_base_decode.sv */
// Purpose: RAM base address from the base bits, size switches and alignment.
// Assumes: Size code selects a 2K to 16K region.
// Notes: Purely combinational; the top module registers the result.
`timescale 1ns/100ps
module mmc_base_decode (
   input wire logic [4:0] ram_base_bits, // Upper five base bits.
   input wire logic ram_high_align, // Align RAM to top of region.
   input wire logic [2:0] ram_size_switches, // Allocated RAM size code.
   output logic [15:0] ram_base // Resulting RAM base address.
);
   logic [15:0] region_mask;
   logic [15:0] region_base;
   logic [15:0] region_size;
   logic [15:0] alloc_size;

   // Each doubling of region size decodes one fewer base bit.
   always_comb begin
      unique case (ram_size_switches)
         3'h0: region_size = 16'h0800;
         3'h1: region_size = 16'h1000;
         3'h2, 3'h3: region_size = 16'h2000;
         default: region_size = 16'h4000;
      endcase
      alloc_size = 16'({ram_size_switches, 11'h000}) + 16'h0800;
      region_mask = ~(region_size - 16'h0001);
      region_base = {ram_base_bits, 11'h000} & region_mask;
      // A small array sits low or high inside a larger region.
      if (ram_high_align) begin
         ram_base = region_base + region_size - alloc_size;
      end else begin
         ram_base = region_base;
      end
   end
endmodule // mmc_base_decode

/* rtl/mmc_once_gate.sv */
// Purpose: Write permission for one write-once register or bit group.
// Assumes: Mode is stable while software runs.
// Notes: The written flag clears only on reset.
`timescale 1ns/100ps
module mmc_once_gate (
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic wr_req, // Write strobe for this group.
   input wire logic special_mode, // High in special modes.
   input wire logic once_en, // High when the group is write-once at all.
   output logic wr_ok // Write may be applied this cycle.
);
   logic written_reg;

   // Permission is combinational so the write lands on the access edge.
   assign wr_ok = wr_req && (special_mode || !once_en || !written_reg);

   // The first accepted write in normal or emulation mode locks the group.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         written_reg <= 1'b0;
      end else if (wr_req && !special_mode && once_en) begin
         written_reg <= 1'b1;
      end
   end
endmodule // mmc_once_gate

/* rtl/mmc_pkg.sv */
// Purpose: Shared constants for the memory-map configuration register bank.
// Assumes: 8-bit register fields placed in the low bits of 32-bit APB words.
// Notes: Printed offsets are not word multiples, so they are register indices.
package mmc_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0] IDX_RAM_POS = 8'h10;
   localparam logic [7:0] IDX_REG_POS = 8'h11;
   localparam logic [7:0] IDX_EE_POS = 8'h12;
   localparam logic [7:0] IDX_MISC = 8'h13;
   localparam logic [7:0] IDX_TEST0 = 8'h14;
   localparam logic [7:0] IDX_TEST1 = 8'h17;
   localparam logic [7:0] IDX_MEMORY_SIZE_STATUS_ZERO = 8'h1c;
   localparam int ADDR_W = 10;
   localparam int IDX_LSB = 2;
   // Reset values.
   localparam logic [7:0] RAM_POS_RST = 8'h09;
   localparam logic [3:0] REG_POS_RST = 4'h0;
   localparam logic [4:0] EE_BASE_RST = 5'h00;
   localparam logic EE_ON_RST = 1'b0;
   localparam logic [1:0] STRETCH_RST = 2'h3;
   localparam logic PROGRAM_MEMORY_UPPER_HALF_ONLY_RST = 1'b0;
   localparam logic [7:0] TEST_RD_VAL = 8'h00;
   // Field positions.
   localparam int BASE_HI = 7;
   localparam int BASE_LO = 3;
   localparam int RAM_HIGH_ALIGN_BIT = 0;
   localparam int EEPROM_MAP_ENABLE_BIT = 0;
   localparam int REGB_HI = 6;
   localparam int STR_HI = 3;
   localparam int STR_LO = 2;
   localparam int PROGRAM_MEMORY_UPPER_HALF_ONLY_BIT = 1;
   localparam int PROGRAM_MEMORY_MAP_ENABLE_BIT = 0;
   // Operating modes of the core.
   typedef enum logic [1:0] {
      MMC_MODE_SINGLE,
      MMC_MODE_EXPANDED,
      MMC_MODE_SPECIAL_TEST,
      MMC_MODE_SPECIAL_SINGLE
   } mmc_mode_t;
endpackage

/* rtl/mmc_regs.sv */
// Purpose: APB register bank that places RAM, registers, EEPROM and program memory.
// Assumes: One 20 MHz clock; mode and size switches are quasi-static straps.
// Notes: Map outputs follow a write by one cycle through a second register stage.
//
// Summary of operation
// - RAM position reads always; write-once in normal/emulation, free in special modes.
// - Map outputs change one clock after a position or control write.
// - Five RAM base bits form the top five bits of RAM base.
// - High-align clear puts RAM low in region, set puts it high.
// - Register position and control bits write-once normally, unlimited in special modes.
// - Register block is 1K or 2K, 2K aligned, within lowest 32K.
// - Register base is zero then four position bits, range 0 to 7FFF.
// - EEPROM enable writable always; position bits optionally write-once.
// - Five EEPROM base bits form the top of the EEPROM base.
// - EEPROM enable set shows EEPROM in map, clear removes it.
// - Stretch field adds zero to three bus cycles to external accesses.
// - Stretch has no effect in normal and special single-chip modes.
// - Upper-half-only blocks direct low-half program memory, page window still works.
// - Program-memory enable adds or removes program memory from the map.
// - Control resets: top bits zero, stretch 11, upper-half zero, enable by mode.
// - Test registers always readable; writes change nothing.
// - Size status shows live size switches and ignores writes.
// - Register size switch reads 1 for 2K, 0 for 1K.
// - EEPROM size code 00/01/10/11 means 0K/2K/4K/8K.
// - RAM size code picks size, mappable region and decoded base bits.
// - RAM position resets to 09, giving base per size code.
// - Smaller RAM sits at region low or high end per high-align.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module mmc_regs #(
   parameter bit EE_POS_ONCE = 1'b0, // Integration choice: EEPROM base write-once.
   parameter bit PROGRAM_MEMORY_MAP_ENABLE_EXP_RST = 1'b1 // Integration reset of program enable in expanded mode.
) (
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction.
   input wire logic [9:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [1:0] op_mode, // Operating mode straps.
   input wire logic register_space_size_switch, // Register space size strap.
   input wire logic [1:0] eeprom_size_switches, // EEPROM size straps.
   input wire logic [2:0] ram_size_switches, // RAM size straps.
   output logic [15:0] ram_base_addr, // Effective RAM base.
   output logic [15:0] reg_base_addr, // Effective register block base.
   output logic reg_space_2k, // Register block spans 2K.
   output logic [15:0] eeprom_base_addr, // Effective EEPROM base.
   output logic eeprom_map_on, // EEPROM present in map.
   output logic [1:0] ext_stretch_cycles, // Extra cycles per external access.
   output logic program_memory_upper_half_only, // Low-half direct access blocked.
   output logic program_memory_map_enable // Program memory present in map.
);
   logic [7:0] ram_position_reg;
   logic [3:0] register_block_position_reg;
   logic [4:0] eeprom_base_bits;
   logic eeprom_map_enable;
   logic [1:0] external_stretch;
   logic upper_half_reg;
   logic program_memory_map_enable_reg;
   logic [1:0] sw_sync1_reg, sw_sync2_reg;
   logic [5:0] sz_sync1_reg, sz_sync2_reg;
   logic straps_caught_reg;
   logic special_mode, ext_mode, single_mode;
   logic wr;
   logic [7:0] idx;
   logic [7:0] memory_size_status_zero_reg;
   logic [7:0] rdata8;
   logic hit;
   logic wr_ram_ok, wr_reg_ok, wr_ee_ok, wr_misc_ok;
   logic [15:0] ram_base_now;
   logic [7:0] wd;
   logic [1:0] strap_age_reg;
   logic sw_straps_valid;

   assign wd = pwdata[7:0];
   assign idx = paddr[mmc_pkg::ADDR_W-1:mmc_pkg::IDX_LSB];
   // A write lands only on the edge that completes the access phase.
   assign wr = psel && penable && pready && pwrite;

   // Straps come from outside this clock domain, so two flops first.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sw_sync1_reg <= 2'h0;
         sw_sync2_reg <= 2'h0;
         sz_sync1_reg <= 6'h00;
         sz_sync2_reg <= 6'h00;
      end else begin
         sw_sync1_reg <= op_mode;
         sw_sync2_reg <= sw_sync1_reg;
         sz_sync1_reg <= {register_space_size_switch, eeprom_size_switches, ram_size_switches};
         sz_sync2_reg <= sz_sync1_reg;
      end
   end

   assign special_mode = (sw_sync2_reg == mmc_pkg::MMC_MODE_SPECIAL_TEST) ||
                         (sw_sync2_reg == mmc_pkg::MMC_MODE_SPECIAL_SINGLE);
   assign ext_mode = (sw_sync2_reg == mmc_pkg::MMC_MODE_EXPANDED);
   assign single_mode = (sw_sync2_reg == mmc_pkg::MMC_MODE_SINGLE) ||
                        (sw_sync2_reg == mmc_pkg::MMC_MODE_SPECIAL_SINGLE);

   // Size status is a live view of the switches, bits 6 and 3 fixed zero.
   assign memory_size_status_zero_reg = {sz_sync2_reg[5], 1'b0, sz_sync2_reg[4:3], 1'b0, sz_sync2_reg[2:0]};

   // Write-once permission per group.
   mmc_once_gate u_once_ram (
      .clk(clk), .reset(reset), .wr_req(wr && idx == mmc_pkg::IDX_RAM_POS),
      .special_mode(special_mode), .once_en(1'b1), .wr_ok(wr_ram_ok));
   mmc_once_gate u_once_reg (
      .clk(clk), .reset(reset), .wr_req(wr && idx == mmc_pkg::IDX_REG_POS),
      .special_mode(special_mode), .once_en(1'b1), .wr_ok(wr_reg_ok));
   mmc_once_gate u_once_ee (
      .clk(clk), .reset(reset), .wr_req(wr && idx == mmc_pkg::IDX_EE_POS),
      .special_mode(special_mode), .once_en(EE_POS_ONCE), .wr_ok(wr_ee_ok));
   mmc_once_gate u_once_misc (
      .clk(clk), .reset(reset), .wr_req(wr && idx == mmc_pkg::IDX_MISC),
      .special_mode(special_mode), .once_en(1'b1), .wr_ok(wr_misc_ok));

   // RAM position keeps only base bits and high-align; others read zero.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ram_position_reg <= mmc_pkg::RAM_POS_RST;
      end else if (wr_ram_ok) begin
         ram_position_reg <= {wd[mmc_pkg::BASE_HI:mmc_pkg::BASE_LO], 2'h0, wd[mmc_pkg::RAM_HIGH_ALIGN_BIT]};
      end
   end

   // Register block position; bit 7 is fixed zero so the base stays below 32K.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         register_block_position_reg <= mmc_pkg::REG_POS_RST;
      end else if (wr_reg_ok) begin
         register_block_position_reg <= wd[mmc_pkg::REGB_HI:mmc_pkg::BASE_LO];
      end
   end

   // EEPROM enable is free at all times; base bits follow the gate.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         eeprom_map_enable <= mmc_pkg::EE_ON_RST;
         eeprom_base_bits <= mmc_pkg::EE_BASE_RST;
      end else if (wr && idx == mmc_pkg::IDX_EE_POS) begin
         eeprom_map_enable <= wd[mmc_pkg::EEPROM_MAP_ENABLE_BIT];
         if (wr_ee_ok) begin
            eeprom_base_bits <= wd[mmc_pkg::BASE_HI:mmc_pkg::BASE_LO];
         end
      end
   end

   // Program enable reset depends on mode, which a constant reset cannot see,
   // so it is loaded from the synchronised straps on each clock after release until they are valid.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         external_stretch <= mmc_pkg::STRETCH_RST;
         upper_half_reg <= mmc_pkg::PROGRAM_MEMORY_UPPER_HALF_ONLY_RST;
         program_memory_map_enable_reg <= 1'b0;
         straps_caught_reg <= 1'b0;
      end else if (wr_misc_ok) begin
         external_stretch <= wd[mmc_pkg::STR_HI:mmc_pkg::STR_LO];
         upper_half_reg <= wd[mmc_pkg::PROGRAM_MEMORY_UPPER_HALF_ONLY_BIT];
         program_memory_map_enable_reg <= wd[mmc_pkg::PROGRAM_MEMORY_MAP_ENABLE_BIT];
         straps_caught_reg <= 1'b1;
      end else if (!straps_caught_reg) begin
         straps_caught_reg <= sw_straps_valid;
         if (sw_sync2_reg == mmc_pkg::MMC_MODE_SPECIAL_TEST) begin
            program_memory_map_enable_reg <= 1'b0;
         end else if (ext_mode) begin
            program_memory_map_enable_reg <= PROGRAM_MEMORY_MAP_ENABLE_EXP_RST;
         end else begin
            program_memory_map_enable_reg <= 1'b1;
         end
      end
   end

   // Straps are valid once they have crossed both synchroniser flops.
   assign sw_straps_valid = strap_age_reg[1];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strap_age_reg <= 2'h0;
      end else begin
         strap_age_reg <= {strap_age_reg[0], 1'b1};
      end
   end

   mmc_base_decode u_ram_base (
      .ram_base_bits(ram_position_reg[mmc_pkg::BASE_HI:mmc_pkg::BASE_LO]),
      .ram_high_align(ram_position_reg[mmc_pkg::RAM_HIGH_ALIGN_BIT]),
      .ram_size_switches(sz_sync2_reg[2:0]),
      .ram_base(ram_base_now)
   );

   // Second stage drives the map so a write is seen one cycle later.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ram_base_addr <= 16'h0000;
         reg_base_addr <= 16'h0000;
         reg_space_2k <= 1'b0;
         eeprom_base_addr <= 16'h0000;
         eeprom_map_on <= 1'b0;
         ext_stretch_cycles <= 2'h0;
         program_memory_upper_half_only <= 1'b0;
         program_memory_map_enable <= 1'b0;
      end else begin
         ram_base_addr <= ram_base_now;
         reg_base_addr <= {1'b0, register_block_position_reg, 11'h000};
         reg_space_2k <= sz_sync2_reg[5];
         eeprom_base_addr <= {eeprom_base_bits, 11'h000};
         eeprom_map_on <= eeprom_map_enable;
         ext_stretch_cycles <= single_mode ? 2'h0 : external_stretch;
         program_memory_upper_half_only <= upper_half_reg;
         program_memory_map_enable <= program_memory_map_enable_reg;
      end
   end

   // Read mux; test registers read fixed values and ignore writes.
   always_comb begin
      hit = 1'b1;
      unique case (idx)
         mmc_pkg::IDX_RAM_POS: rdata8 = ram_position_reg;
         mmc_pkg::IDX_REG_POS: rdata8 = {1'b0, register_block_position_reg, 3'h0};
         mmc_pkg::IDX_EE_POS: rdata8 = {eeprom_base_bits, 2'h0, eeprom_map_enable};
         mmc_pkg::IDX_MISC: rdata8 = {4'h0, external_stretch, upper_half_reg, program_memory_map_enable_reg};
         mmc_pkg::IDX_TEST0, mmc_pkg::IDX_TEST1: rdata8 = mmc_pkg::TEST_RD_VAL;
         mmc_pkg::IDX_MEMORY_SIZE_STATUS_ZERO: rdata8 = memory_size_status_zero_reg;
         default: begin
            rdata8 = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   // Zero-wait slave: ready is registered from the setup phase, so each transfer takes two cycles.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= (psel && !penable && !pwrite) ? {24'h000000, rdata8} : 32'h0000_0000;
      end
   end

   // The map view must not move in the cycle right after an accepted RAM write.
   chk_ram_delay: assert property (@(posedge clk) disable iff (reset)
      (wr_ram_ok && $stable(sz_sync2_reg)) |=> $stable(ram_base_addr)) else $error("RAM map lag wrong");
   chk_ram_lock: assert property (@(posedge clk) disable iff (reset)
      (!special_mode && u_once_ram.written_reg && !$changed(sw_sync2_reg)) |=> $stable(ram_position_reg))
      else $error("RAM position rewritten");
   chk_reg_lock: assert property (@(posedge clk) disable iff (reset)
      (!special_mode && u_once_reg.written_reg) |=> $stable(register_block_position_reg))
      else $error("Register position rewritten");
   chk_reg_range: assert property (@(posedge clk) disable iff (reset)
      reg_base_addr[15] == 1'b0) else $error("Register base above 32K");
   chk_ee_enable: assert property (@(posedge clk) disable iff (reset)
      (wr && idx == mmc_pkg::IDX_EE_POS) |=> ##1 (eeprom_map_on == $past(wd[mmc_pkg::EEPROM_MAP_ENABLE_BIT], 2)))
      else $error("EEPROM enable not applied");
   chk_stretch_single: assert property (@(posedge clk) disable iff (reset)
      $past(single_mode) |-> ext_stretch_cycles == 2'h0) else $error("Stretch in single chip");
   chk_misc_top_zero: assert property (@(posedge clk) disable iff (reset)
      (psel && !penable && !pwrite && idx == mmc_pkg::IDX_MISC)
      |=> prdata[7:4] == 4'h0) else $error("Control top bits not zero");
   chk_test_ro: assert property (@(posedge clk) disable iff (reset)
      (psel && !penable && !pwrite && (idx == mmc_pkg::IDX_TEST0 || idx == mmc_pkg::IDX_TEST1))
      |=> prdata == 32'h0000_0000) else $error("Test register read nonzero");
endmodule // mmc_regs

/* tb/mmc_cpu_model.sv */
// Purpose: CPU-side APB master that issues register reads and writes.
// Assumes: Single clock; the slave answers with pready in the access phase.
// Notes: Idle address and data lines carry the inverse of the last request.
`timescale 1ns/100ps
module mmc_cpu_model (
   input wire logic clk, // System clock.
   output logic psel, // APB select.
   output logic penable, // APB access phase.
   output logic pwrite, // APB direction.
   output logic [9:0] paddr, // APB byte address.
   output logic [31:0] pwdata, // APB write data.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr // APB error.
);
   // Quiet bus at time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h00000000;
   end

   // One transfer; it waits for pready as long as it takes, only the bench watchdog ends a dead wait.
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~{24'h000000, d};
   endtask
endmodule // mmc_cpu_model

/* tb/tb_memory_map_config_registers.sv */
// Purpose: Self-checking bench for the memory-map configuration register bank.
// Assumes: Straps change only with settling time before they are checked.
// Notes: Mode changes go through reset, as reset values depend on mode.
`timescale 1ns/100ps
module tb_memory_map_config_registers;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, register_space_size_switch;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] op_mode, eeprom_size_switches, ext_stretch_cycles;
   logic [2:0] ram_size_switches;
   logic [15:0] ram_base_addr, reg_base_addr, eeprom_base_addr;
   logic reg_space_2k, eeprom_map_on, program_memory_upper_half_only, program_memory_map_enable;
   int n_fail = 0;
   int checks_done = 0;

   mmc_regs #(.EE_POS_ONCE(1'b0), .PROGRAM_MEMORY_MAP_ENABLE_EXP_RST(1'b1)) dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
      .register_space_size_switch(register_space_size_switch),
      .eeprom_size_switches(eeprom_size_switches), .ram_size_switches(ram_size_switches),
      .ram_base_addr(ram_base_addr), .reg_base_addr(reg_base_addr), .reg_space_2k(reg_space_2k),
      .eeprom_base_addr(eeprom_base_addr), .eeprom_map_on(eeprom_map_on),
      .ext_stretch_cycles(ext_stretch_cycles),
      .program_memory_upper_half_only(program_memory_upper_half_only),
      .program_memory_map_enable(program_memory_map_enable));

   mmc_cpu_model cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Clock at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic complete_run();
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      cpu.xfer(1'b1, {idx, 2'b00}, d, q, e);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic err);
      logic [31:0] q;
      logic e;
      cpu.xfer(1'b0, {idx, 2'b00}, 8'h00, q, e);
      chk(32'(e), 32'(err));
      if (!err) chk(q, {24'h000000, exp});
   endtask

   // Map outputs lag the register by one edge.
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic do_reset(input logic [1:0] m, input logic [2:0] c);
      @(posedge clk);
      reset <= 1'b1;
      op_mode <= m;
      ram_size_switches <= c;
      eeprom_size_switches <= c[1:0];
      register_space_size_switch <= c[0];
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic t_modes();
      logic [7:0] mx [4] = '{8'h0d, 8'h0d, 8'h0c, 8'h0d};
      logic [1:0] sx [4] = '{2'h0, 2'h3, 2'h3, 2'h0};
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1:0], 3'h0);
         chk(32'(ext_stretch_cycles), 32'(sx[m]));
         chk(32'(program_memory_map_enable), 32'(mx[m][0]));
         chk(32'(program_memory_upper_half_only), 32'h0);
         chk(32'(eeprom_map_on), 32'h0);
         rd(mmc_pkg::IDX_RAM_POS, 8'h09, 1'b0);
         rd(mmc_pkg::IDX_MISC, mx[m], 1'b0);
      end
   endtask

   task automatic t_sizes();
      logic [2:0] k;
      // RAM base after reset for each size code, as the size table lists it.
      logic [15:0] bx [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000, 16'h1800, 16'h1000, 16'h0800, 16'h0000};
      for (int c = 0; c < 8; c++) begin
         k = c[2:0];
         @(posedge clk);
         ram_size_switches <= k;
         eeprom_size_switches <= k[1:0];
         register_space_size_switch <= k[0];
         repeat (6) @(posedge clk);
         #1;
         chk(ram_base_addr, bx[c]);
         chk(32'(reg_space_2k), 32'(k[0]));
         rd(mmc_pkg::IDX_MEMORY_SIZE_STATUS_ZERO, {k[0], 1'b0, k[1:0], 1'b0, k}, 1'b0);
      end
   endtask

   task automatic t_normal();
      do_reset(2'h0, 3'h0);
      wr(mmc_pkg::IDX_RAM_POS, 8'h39);
      #1;
      chk(ram_base_addr, 16'h0800);
      settle();
      chk(ram_base_addr, 16'h3800);
      wr(mmc_pkg::IDX_RAM_POS, 8'h41);
      rd(mmc_pkg::IDX_RAM_POS, 8'h39, 1'b0);
      wr(mmc_pkg::IDX_REG_POS, 8'h10);
      wr(mmc_pkg::IDX_REG_POS, 8'h20);
      rd(mmc_pkg::IDX_REG_POS, 8'h10, 1'b0);
      wr(mmc_pkg::IDX_MISC, 8'h00);
      wr(mmc_pkg::IDX_MISC, 8'h0f);
      rd(mmc_pkg::IDX_MISC, 8'h00, 1'b0);
      chk(32'(program_memory_map_enable), 32'h0);
      wr(mmc_pkg::IDX_EE_POS, 8'h81);
      settle();
      chk(eeprom_base_addr, 16'h8000);
      chk(32'(eeprom_map_on), 32'h1);
      wr(mmc_pkg::IDX_EE_POS, 8'h40);
      settle();
      chk(eeprom_base_addr, 16'h4000);
      chk(32'(eeprom_map_on), 32'h0);
   endtask

   task automatic t_special();
      logic [1:0] s;
      do_reset(2'h2, 3'h4);
      wr(mmc_pkg::IDX_RAM_POS, 8'hb8);
      settle();
      chk(ram_base_addr, 16'h8000);
      wr(mmc_pkg::IDX_RAM_POS, 8'hb9);
      settle();
      chk(ram_base_addr, 16'h9800);
      wr(mmc_pkg::IDX_REG_POS, 8'hff);
      settle();
      chk(reg_base_addr, 16'h7800);
      rd(mmc_pkg::IDX_REG_POS, 8'h78, 1'b0);
      wr(mmc_pkg::IDX_REG_POS, 8'h08);
      settle();
      chk(reg_base_addr, 16'h0800);
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         wr(mmc_pkg::IDX_MISC, {4'hf, s, s});
         settle();
         chk(32'(ext_stretch_cycles), 32'(s));
         chk(32'(program_memory_upper_half_only), 32'(s[1]));
         chk(32'(program_memory_map_enable), 32'(s[0]));
         rd(mmc_pkg::IDX_MISC, {4'h0, s, s}, 1'b0);
      end
   endtask

   task automatic t_readonly();
      wr(mmc_pkg::IDX_TEST0, 8'hff);
      rd(mmc_pkg::IDX_TEST0, 8'h00, 1'b0);
      wr(mmc_pkg::IDX_TEST1, 8'hff);
      rd(mmc_pkg::IDX_TEST1, 8'h00, 1'b0);
      wr(mmc_pkg::IDX_MEMORY_SIZE_STATUS_ZERO, 8'hff);
      rd(mmc_pkg::IDX_MEMORY_SIZE_STATUS_ZERO, 8'h04, 1'b0);
      rd(8'hff, 8'h00, 1'b1);
   endtask

   // Main sequence; every input gets a value at time zero.
   initial begin
      reset = 1'b1;
      op_mode = 2'h0;
      ram_size_switches = 3'h0;
      eeprom_size_switches = 2'h0;
      register_space_size_switch = 1'b0;
      t_modes();
      t_sizes();
      t_normal();
      t_special();
      t_readonly();
      complete_run();
   end

   // Watchdog at 20000 cycles, far beyond the few hundred cycles the run needs.
   initial begin
      #(50 * 20000);
      n_fail++;
      complete_run();
   end
endmodule // tb_memory_map_config_registers
